// ---- src/tmr8_pkg.sv ----
// Purpose: Shared constants and types of the 8-bit timer with one compare channel
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes: Register layout and offsets are fixed here only
package tmr8_pkg;
  // Register byte addresses
  localparam logic [7:0] TMR8_CTRL_ADDR = 8'h00;
  localparam logic [7:0] TMR8_COUNT_ADDR = 8'h04;
  localparam logic [7:0] TMR8_COMPARE_ADDR = 8'h08;
  localparam logic [7:0] TMR8_FLAG_ADDR = 8'h0C;
  localparam logic [7:0] TMR8_MASK_ADDR = 8'h10;
  // Field positions
  localparam int TMR8_FORCE_BIT = 7;
  localparam int TMR8_CMP_FLAG_BIT = 1;
  localparam int TMR8_OVF_FLAG_BIT = 0;
  // Counter landmarks
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX = 8'hFF;
  localparam logic [7:0] TMR8_RESET_VAL = 8'h00;
  // Clock select codes
  localparam logic [2:0] TMR8_CS_STOP = 3'h0;
  localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7;
  // Compare output mode codes
  localparam logic [1:0] TMR8_COM_OFF = 2'h0;
  localparam logic [1:0] TMR8_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR8_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMR8_COM_SET = 2'h3;
  // Bus responses
  localparam logic [1:0] TMR8_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR8_RESP_SLVERR = 2'h2;
  // Prescaler width
  localparam int TMR8_PRE_W = 10;
  // Waveform generation modes, in code order
  typedef enum logic [1:0] {
    TMR8_WGM_NORMAL,
    TMR8_WGM_PHASE_PWM,
    TMR8_WGM_CTC,
    TMR8_WGM_FAST_PWM
  } tmr8_wgm_t;
  // Control register image
  typedef struct packed {
    logic [1:0] compare_output_mode;
    tmr8_wgm_t waveform_mode;
    logic [2:0] clock_select;
  } tmr8_ctrl_t;
  localparam tmr8_ctrl_t TMR8_CTRL_RESET = '{TMR8_COM_OFF, TMR8_WGM_NORMAL, TMR8_CS_STOP};
endpackage : tmr8_pkg

// ---- src/tmr8_timer.sv ----
// Purpose: 8-bit timer/counter with one output compare channel behind AXI4-Lite
// Assumes: One clock; external count input is asynchronous
// Notes: Interrupt requests are qualified by the processor global enable
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tmr8_timer
  import tmr8_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_count_input_i,
  input wire logic global_irq_enable_i,
  input wire logic compare_irq_ack_i,
  input wire logic overflow_irq_ack_i,
  output logic compare_output_o,
  output logic compare_output_en_o,
  output logic compare_irq_o,
  output logic overflow_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tmr8_ctrl_t ctrl_ff;
  logic [7:0] count_value_ff;
  logic [7:0] nxt_count_value;
  logic [7:0] compare_value_ff;
  logic [7:0] compare_buffer_ff;
  logic compare_flag_ff;
  logic overflow_flag_ff;
  logic compare_irq_enable_ff;
  logic overflow_irq_enable_ff;
  logic count_down_ff;
  logic nxt_count_down;
  logic block_ff;
  logic oc_ff;
  logic [TMR8_PRE_W-1:0] pre_ff;
  logic [2:0] ext_sync_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic wr_lane;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flag;
  logic wr_mask;
  logic force_go;
  logic timer_tick;
  logic ext_rise;
  logic ext_fall;
  logic pwm_mode;
  logic at_bottom;
  logic at_max;
  logic [7:0] top_value;
  logic match;
  logic cmp_event;
  logic tov_set;
  logic buf_load;
  tmr8_ctrl_t wr_ctrl_img;

  // Register decode, shared by read and write paths
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_is = (a == off[ADDR_W-1:0]);
  endfunction : addr_is

  // Prescaler tap: true on the last count of a divide-by period
  function automatic logic pre_tap(input logic [2:0] cs, input logic [TMR8_PRE_W-1:0] p);
    case (cs)
      3'h1: pre_tap = 1'b1;
      3'h2: pre_tap = (p[2:0] == 3'h7);
      3'h3: pre_tap = (p[5:0] == 6'h3F);
      3'h4: pre_tap = (p[7:0] == 8'hFF);
      3'h5: pre_tap = (p == 10'h3FF);
      default: pre_tap = 1'b0;
    endcase
  endfunction : pre_tap

  // PWM mode decode, for the live and for the written mode
  function automatic logic is_pwm(input tmr8_wgm_t w);
    is_pwm = (w == TMR8_WGM_PHASE_PWM) || (w == TMR8_WGM_FAST_PWM);
  endfunction : is_pwm

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_lane = wr_go && wstrb_ff[0];
  assign wr_ctrl = wr_lane && addr_is(awaddr_ff, TMR8_CTRL_ADDR);
  assign wr_count = wr_lane && addr_is(awaddr_ff, TMR8_COUNT_ADDR);
  assign wr_compare = wr_lane && addr_is(awaddr_ff, TMR8_COMPARE_ADDR);
  assign wr_flag = wr_lane && addr_is(awaddr_ff, TMR8_FLAG_ADDR);
  assign wr_mask = wr_lane && addr_is(awaddr_ff, TMR8_MASK_ADDR);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Address and data latch independently, response after both
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= TMR8_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_ctrl || wr_count || wr_compare || wr_flag || wr_mask || !wstrb_ff[0]) &&
                    (addr_is(awaddr_ff, TMR8_CTRL_ADDR) || addr_is(awaddr_ff, TMR8_COUNT_ADDR) ||
                     addr_is(awaddr_ff, TMR8_COMPARE_ADDR) || addr_is(awaddr_ff, TMR8_FLAG_ADDR) ||
                     addr_is(awaddr_ff, TMR8_MASK_ADDR)) ? TMR8_RESP_OKAY : TMR8_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Read mux; compare reads show the buffer in PWM modes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= TMR8_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= TMR8_RESP_OKAY;
      if (addr_is(s_axi_araddr, TMR8_CTRL_ADDR)) begin
        rdata_ff <= {25'h0, ctrl_ff};
      end else if (addr_is(s_axi_araddr, TMR8_COUNT_ADDR)) begin
        rdata_ff <= {24'h0, count_value_ff};
      end else if (addr_is(s_axi_araddr, TMR8_COMPARE_ADDR)) begin
        rdata_ff <= {24'h0, pwm_mode ? compare_buffer_ff : compare_value_ff};
      end else if (addr_is(s_axi_araddr, TMR8_FLAG_ADDR)) begin
        rdata_ff <= {30'h0, compare_flag_ff, overflow_flag_ff};
      end else if (addr_is(s_axi_araddr, TMR8_MASK_ADDR)) begin
        rdata_ff <= {30'h0, compare_irq_enable_ff, overflow_irq_enable_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= TMR8_RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and mask registers
  // Force strobe acts with the mode bits written alongside it
  assign wr_ctrl_img = tmr8_ctrl_t'(wdata_ff[6:0]);
  assign force_go = wr_ctrl && wdata_ff[TMR8_FORCE_BIT] && !is_pwm(wr_ctrl_img.waveform_mode);

  // Control changes apply at once, including output mode
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_ff <= TMR8_CTRL_RESET;
      compare_irq_enable_ff <= 1'b0;
      overflow_irq_enable_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wr_ctrl_img;
      end
      if (wr_mask) begin
        compare_irq_enable_ff <= wdata_ff[TMR8_CMP_FLAG_BIT];
        overflow_irq_enable_ff <= wdata_ff[TMR8_OVF_FLAG_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock select: prescaler and external input
  assign ext_rise = ext_sync_ff[1] && !ext_sync_ff[2];
  assign ext_fall = !ext_sync_ff[1] && ext_sync_ff[2];

  // Three-stage sync of the count pin, edges from stages two and three
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_sync_ff <= 3'h0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], external_count_input_i};
    end
  end

  // Free-running prescaler, held while stopped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_ff <= '0;
    end else if (ctrl_ff.clock_select != TMR8_CS_STOP) begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // Timer clock enable pulse
  always_comb begin
    case (ctrl_ff.clock_select)
      TMR8_CS_STOP: timer_tick = 1'b0;
      TMR8_CS_EXT_FALL: timer_tick = ext_fall;
      TMR8_CS_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = pre_tap(ctrl_ff.clock_select, pre_ff);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter unit
  assign pwm_mode = is_pwm(ctrl_ff.waveform_mode);
  assign at_bottom = (count_value_ff == TMR8_BOTTOM);
  assign at_max = (count_value_ff == TMR8_MAX);
  assign top_value = (ctrl_ff.waveform_mode == TMR8_WGM_CTC) ? compare_value_ff : TMR8_MAX;
  assign match = (count_value_ff == compare_value_ff);
  assign cmp_event = timer_tick && match && !block_ff;

  // Next count, direction and overflow per waveform mode
  always_comb begin
    nxt_count_value = count_value_ff;
    nxt_count_down = count_down_ff;
    tov_set = 1'b0;
    if (timer_tick) begin
      case (ctrl_ff.waveform_mode)
        TMR8_WGM_NORMAL: begin
          nxt_count_value = count_value_ff + 8'h01;
          tov_set = at_max;
          nxt_count_down = 1'b0;
        end
        TMR8_WGM_CTC: begin
          nxt_count_value = (count_value_ff == top_value) ? TMR8_BOTTOM : count_value_ff + 8'h01;
          tov_set = at_max;
          nxt_count_down = 1'b0;
        end
        TMR8_WGM_FAST_PWM: begin
          nxt_count_value = at_max ? TMR8_BOTTOM : count_value_ff + 8'h01;
          tov_set = (count_value_ff == TMR8_MAX - 8'h01);
          nxt_count_down = 1'b0;
        end
        TMR8_WGM_PHASE_PWM: begin
          if (!count_down_ff) begin
            nxt_count_down = at_max;
            nxt_count_value = at_max ? count_value_ff - 8'h01 : count_value_ff + 8'h01;
          end else begin
            nxt_count_down = !at_bottom;
            nxt_count_value = at_bottom ? count_value_ff + 8'h01 : count_value_ff - 8'h01;
            tov_set = at_bottom;
          end
        end
        default: nxt_count_value = count_value_ff;
      endcase
    end
  end

  // Counter register: processor write has priority
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_value_ff <= TMR8_RESET_VAL;
      count_down_ff <= 1'b0;
    end else begin
      count_down_ff <= nxt_count_down;
      if (wr_count) begin
        count_value_ff <= wdata_ff[7:0];
      end else begin
        count_value_ff <= nxt_count_value;
      end
    end
  end

  // Match block armed by counter writes until the next tick
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      block_ff <= 1'b0;
    end else if (wr_count) begin
      block_ff <= 1'b1;
    end else if (timer_tick) begin
      block_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare register and its buffer
  assign buf_load = pwm_mode && timer_tick && at_max;

  // Direct update outside PWM, TOP-synchronised load inside
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      compare_value_ff <= TMR8_RESET_VAL;
      compare_buffer_ff <= TMR8_RESET_VAL;
    end else begin
      if (wr_compare) begin
        compare_buffer_ff <= wdata_ff[7:0];
      end
      if (wr_compare && !pwm_mode) begin
        compare_value_ff <= wdata_ff[7:0];
      end else if (buf_load) begin
        compare_value_ff <= compare_buffer_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      compare_flag_ff <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else begin
      if (cmp_event) begin
        compare_flag_ff <= 1'b1;
      end else if (compare_irq_ack_i || (wr_flag && wdata_ff[TMR8_CMP_FLAG_BIT])) begin
        compare_flag_ff <= 1'b0;
      end
      if (tov_set) begin
        overflow_flag_ff <= 1'b1;
      end else if (overflow_irq_ack_i || (wr_flag && wdata_ff[TMR8_OVF_FLAG_BIT])) begin
        overflow_flag_ff <= 1'b0;
      end
    end
  end

  // Interrupt requests
  assign compare_irq_o = compare_flag_ff && compare_irq_enable_ff && global_irq_enable_i;
  assign overflow_irq_o = overflow_flag_ff && overflow_irq_enable_ff && global_irq_enable_i;

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generator; state survives mode changes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc_ff <= 1'b0;
    end else if (force_go || (cmp_event && !pwm_mode)) begin
      case (force_go ? wr_ctrl_img.compare_output_mode : ctrl_ff.compare_output_mode)
        TMR8_COM_TOGGLE: oc_ff <= !oc_ff;
        TMR8_COM_CLEAR: oc_ff <= 1'b0;
        TMR8_COM_SET: oc_ff <= 1'b1;
        default: oc_ff <= oc_ff;
      endcase
    end else if (ctrl_ff.compare_output_mode[1] && pwm_mode) begin
      if (cmp_event) begin
        // Fast: match clears (non-inverted); phase: up clears, down sets
        oc_ff <= ctrl_ff.compare_output_mode[0] ^
                 ((ctrl_ff.waveform_mode == TMR8_WGM_PHASE_PWM) && count_down_ff);
      end else if (timer_tick && at_max && ctrl_ff.waveform_mode == TMR8_WGM_FAST_PWM) begin
        oc_ff <= !ctrl_ff.compare_output_mode[0];
      end
    end
  end

  assign compare_output_o = oc_ff;
  assign compare_output_en_o = (ctrl_ff.compare_output_mode != TMR8_COM_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_stop_holds;
    @(posedge clk_i) disable iff (!nrst_i)
    (ctrl_ff.clock_select == TMR8_CS_STOP) && !wr_count |=> $stable(count_value_ff);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

  property p_write_wins;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_count |=> count_value_ff == $past(wdata_ff[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost");

  property p_normal_wrap;
    @(posedge clk_i) disable iff (!nrst_i)
    timer_tick && at_max && !wr_count && ctrl_ff.waveform_mode == TMR8_WGM_NORMAL
      |=> count_value_ff == TMR8_BOTTOM && overflow_flag_ff;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow wrong");

  property p_ctc_clear;
    @(posedge clk_i) disable iff (!nrst_i)
    timer_tick && match && !wr_count && ctrl_ff.waveform_mode == TMR8_WGM_CTC |=> count_value_ff == TMR8_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear on match missed");

  property p_block;
    @(posedge clk_i) disable iff (!nrst_i)
    block_ff && timer_tick && match && !wr_count && !compare_flag_ff |=> !compare_flag_ff;
  endproperty
  a_block: assert property (p_block) else $error("match after counter write not blocked");

  property p_flag_set;
    @(posedge clk_i) disable iff (!nrst_i)
    cmp_event |=> compare_flag_ff;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("compare flag not set");

  property p_irq;
    @(posedge clk_i) disable iff (!nrst_i)
    compare_irq_o |-> compare_flag_ff && compare_irq_enable_ff && global_irq_enable_i;
  endproperty
  a_irq: assert property (p_irq) else $error("compare irq without cause");

  property p_flag_clear;
    @(posedge clk_i) disable iff (!nrst_i)
    compare_irq_ack_i && !cmp_event |=> !compare_flag_ff;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("compare flag not cleared");

  property p_force_no_flag;
    @(posedge clk_i) disable iff (!nrst_i)
    force_go && !cmp_event && !compare_flag_ff && wr_ctrl_img.compare_output_mode == TMR8_COM_TOGGLE
      |=> !compare_flag_ff && oc_ff != $past(oc_ff);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force strobe misbehaved");

  property p_buffered;
    @(posedge clk_i) disable iff (!nrst_i)
    pwm_mode && !buf_load |=> $stable(compare_value_ff);
  endproperty
  a_buffered: assert property (p_buffered) else $error("active compare changed off TOP");

  c_ctc_match: cover property (@(posedge clk_i) disable iff (!nrst_i)
    cmp_event && ctrl_ff.waveform_mode == TMR8_WGM_CTC);
  c_phase_turn: cover property (@(posedge clk_i) disable iff (!nrst_i)
    tov_set && ctrl_ff.waveform_mode == TMR8_WGM_PHASE_PWM);
  c_buf_load: cover property (@(posedge clk_i) disable iff (!nrst_i) buf_load);

endmodule : tmr8_timer
`default_nettype wire

// ---- dv/tmr8_cpu_model.sv ----
// Purpose: Processor model that executes pending timer interrupts
// Assumes: Entering an interrupt takes one clock
// Notes: Acknowledge is a one-cycle pulse, only while ack_en_i is high
`timescale 1ns/100ps
`default_nettype none
module tmr8_cpu_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ack_en_i,
  input wire logic cmp_irq_i,
  input wire logic ovf_irq_i,
  output logic cmp_ack_o,
  output logic ovf_ack_o
);
  logic cmp_ack_ff;
  logic ovf_ack_ff;
  // One entry per request, compare served first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_ack_ff <= 1'h0;
      ovf_ack_ff <= 1'h0;
    end else begin
      cmp_ack_ff <= ack_en_i & cmp_irq_i & !cmp_ack_ff;
      ovf_ack_ff <= ack_en_i & ovf_irq_i & !cmp_irq_i & !ovf_ack_ff;
    end
  end
  assign cmp_ack_o = cmp_ack_ff;
  assign ovf_ack_o = ovf_ack_ff;
endmodule : tmr8_cpu_model
`default_nettype wire

// ---- dv/timer8_output_compare_tb.sv ----
// Purpose: Self-checking bench for the timer over AXI4-Lite
// Assumes: Bus answers within 50 cycles
// Notes: Timed runs use clock select 1 (every clk)
`timescale 1ns/100ps
`default_nettype none
module timer8_output_compare_tb import tmr8_pkg::*;;
  logic clk_i = 1'h0, nrst_i = 1'h0, ext_pin = 1'h0, gie = 1'h0, ack_en = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic cmp_ack, ovf_ack, cmp_out, cmp_en, cmp_irq, ovf_irq;
  int fail_count = 0, num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  always #4 clk_i = ~clk_i;
  tmr8_timer DUT (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .external_count_input_i(ext_pin), .global_irq_enable_i(gie), .compare_irq_ack_i(cmp_ack),
    .overflow_irq_ack_i(ovf_ack), .compare_output_o(cmp_out), .compare_output_en_o(cmp_en),
    .compare_irq_o(cmp_irq), .overflow_irq_o(ovf_irq));
  tmr8_cpu_model CPU (.clk_i(clk_i), .nrst_i(nrst_i), .ack_en_i(ack_en), .cmp_irq_i(cmp_irq),
    .ovf_irq_i(ovf_irq), .cmp_ack_o(cmp_ack), .ovf_ack_o(ovf_ack));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask : chk_bit
  task automatic hang;
    fail_count++;
    $display("FAIL bus answer expected 1 seen 0");
    report_and_stop();
  endtask : hang
  ////////////////////////////////////////////////////////////////////////////
  // Bus master: called right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (aw && s_axi_awready === 1'h1) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    if (n >= 50) hang();
    resp = s_axi_bresp;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready === 1'h1 && s_axi_arvalid) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    if (n >= 50) hang();
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rdr
  function automatic logic [31:0] ctl(logic [2:0] cs, logic [1:0] wgm, logic [1:0] com, logic f);
    return {24'h0, f, com, wgm, cs};
  endfunction : ctl
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    hang();
  end
  // Main sequence
  initial begin
    logic [1:0] coms [3];
    coms = '{TMR8_COM_SET, TMR8_COM_CLEAR, TMR8_COM_TOGGLE};
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'h1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      rdr(8'(i * 4));
      chk_word("reset reg", 32'h0, rd);
    end
    chk_bit("out reset", 1'h0, cmp_out);
    wr(TMR8_COUNT_ADDR, 32'hA5);
    wr(TMR8_COMPARE_ADDR, 32'h5A);
    repeat (20) @(posedge clk_i);
    rdr(TMR8_COUNT_ADDR);
    chk_word("count stopped", 32'hA5, rd);
    rdr(TMR8_COMPARE_ADDR);
    chk_word("compare", 32'h5A, rd);
    // Forced actions set, clear, toggle before the pin is used
    for (int i = 0; i < 3; i++) begin
      wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_NORMAL, coms[i], 1'h1));
      chk_bit("forced out", i != 1, cmp_out);
      chk_bit("out enable", 1'h1, cmp_en);
    end
    rdr(TMR8_FLAG_ADDR);
    chk_word("flags after force", 32'h0, rd);
    rdr(TMR8_COUNT_ADDR);
    chk_word("count after force", 32'hA5, rd);
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_FAST_PWM, TMR8_COM_CLEAR, 1'h1));
    chk_bit("out kept, force in pwm", 1'h1, cmp_out);
    wr(TMR8_COMPARE_ADDR, 32'h40);
    rdr(TMR8_COMPARE_ADDR);
    chk_word("buffered compare", 32'h40, rd);
    // Count written equal to compare: first match suppressed
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_NORMAL, TMR8_COM_OFF, 1'h0));
    wr(TMR8_COMPARE_ADDR, 32'h05);
    wr(TMR8_COUNT_ADDR, 32'h05);
    wr(TMR8_CTRL_ADDR, ctl(3'h1, TMR8_WGM_NORMAL, TMR8_COM_OFF, 1'h0));
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_NORMAL, TMR8_COM_OFF, 1'h0));
    rdr(TMR8_FLAG_ADDR);
    chk_word("blocked match", 32'h0, rd);
    rdr(TMR8_COUNT_ADDR);
    chk_bit("count advanced", 1'h1, rd[7:0] > 8'h05 && rd[7:0] < 8'h10);
    // Normal wrap with overflow interrupt, then cleared by writing one to the flag
    wr(TMR8_COMPARE_ADDR, 32'h80);
    wr(TMR8_COUNT_ADDR, 32'hFD);
    wr(TMR8_CTRL_ADDR, ctl(3'h1, TMR8_WGM_NORMAL, TMR8_COM_OFF, 1'h0));
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_NORMAL, TMR8_COM_OFF, 1'h0));
    rdr(TMR8_FLAG_ADDR);
    chk_word("overflow flag", 32'h1, rd);
    gie <= 1'h1;
    wr(TMR8_MASK_ADDR, 32'h1);
    chk_bit("overflow irq", 1'h1, ovf_irq);
    wr(TMR8_FLAG_ADDR, 32'h1);
    chk_bit("overflow cleared by one", 1'h0, ovf_irq);
    // Clear on match with toggling output
    wr(TMR8_COMPARE_ADDR, 32'h03);
    wr(TMR8_COUNT_ADDR, 32'h00);
    wr(TMR8_CTRL_ADDR, ctl(3'h1, TMR8_WGM_CTC, TMR8_COM_TOGGLE, 1'h0));
    repeat (40) @(posedge clk_i);
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_CTC, TMR8_COM_TOGGLE, 1'h0));
    rdr(TMR8_COUNT_ADDR);
    chk_bit("ctc count bound", 1'h1, rd[7:0] <= 8'h03);
    rdr(TMR8_FLAG_ADDR);
    chk_word("compare flag", 32'h2, rd);
    wr(TMR8_MASK_ADDR, 32'h2);
    chk_bit("compare irq", 1'h1, cmp_irq);
    gie <= 1'h0;
    @(posedge clk_i);
    chk_bit("irq masked globally", 1'h0, cmp_irq);
    gie <= 1'h1;
    ack_en <= 1'h1;
    repeat (4) @(posedge clk_i);
    ack_en <= 1'h0;
    rdr(TMR8_FLAG_ADDR);
    chk_word("flag cleared by irq", 32'h0, rd);
    // External rising edges
    wr(TMR8_COUNT_ADDR, 32'h00);
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_EXT_RISE, TMR8_WGM_NORMAL, TMR8_COM_OFF, 1'h0));
    repeat (3) begin
      ext_pin <= 1'h1;
      repeat (6) @(posedge clk_i);
      ext_pin <= 1'h0;
      repeat (6) @(posedge clk_i);
    end
    rdr(TMR8_COUNT_ADDR);
    chk_word("external count", 32'h03, rd);
    // Fast PWM, non-inverted: set at BOTTOM, cleared on match
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_FAST_PWM, TMR8_COM_CLEAR, 1'h0));
    wr(TMR8_COMPARE_ADDR, 32'h10);
    wr(TMR8_COUNT_ADDR, 32'hFE);
    wr(TMR8_CTRL_ADDR, ctl(3'h1, TMR8_WGM_FAST_PWM, TMR8_COM_CLEAR, 1'h0));
    repeat (8) @(posedge clk_i);
    chk_bit("pwm set at bottom", 1'h1, cmp_out);
    repeat (16) @(posedge clk_i);
    chk_bit("pwm cleared on match", 1'h0, cmp_out);
    wr(TMR8_CTRL_ADDR, ctl(TMR8_CS_STOP, TMR8_WGM_FAST_PWM, TMR8_COM_CLEAR, 1'h0));
    rdr(TMR8_FLAG_ADDR);
    chk_word("pwm flags", 32'h3, rd);
    // Unmapped place
    wr(8'h14, 32'h1);
    chk_word("unmapped write resp", 32'(TMR8_RESP_SLVERR), 32'(resp));
    rdr(8'h14);
    chk_word("unmapped read resp", 32'(TMR8_RESP_SLVERR), 32'(resp));
    chk_word("unmapped read data", 32'h0, rd);
    report_and_stop();
  end
endmodule : timer8_output_compare_tb
`default_nettype wire
